// >>> rtl/lpmc_top.v
// Overview of operation
// - Sleep in subactive, 0/1/1, enters subsleep
// - Subsleep halts CPU, stops non-timer peripherals
// - Subsleep retains registers, RAM, port outputs
// - Subsleep ends on interrupt, reset, standby
// - Interrupt wake from subsleep enters subactive
// - Disabled IRQs and CPU-masked peripheral interrupts never wake
// - Reset pin low clocks chip; release starts
// - Standby pin low enters hardware standby
// - Sleep in high-speed, all ones, enters subactive
// - Watch interrupt with low_speed_on goes subactive
// - Subactive runs subclock, only timers, watchdogs
// - Subactive ends by sleep, reset, standby only
// - Sleep in subactive, 1/0/1, enters watch
// - Sleep in subactive, 1/1/0/1, settles then high-speed
// - Direct move to subactive keeps running; back to high-speed halts while settling; then exception starts
// - Stop bits take effect at bus cycle end
// - Stopped modules retain state except serial, PWM
// - All modules stopped after reset
// - Stopped module register access has no effect
// - Software standby keeps port output states
`timescale 1ns/1ps
`include "lpmc_regs.vh"

module lpmc_top #(
  parameter NUM_MOD = 16,
  parameter [15:0] LOWPWR_KEEP_MASK = 16'h000f,
  parameter [15:0] WATCH_KEEP_MASK = 16'h0008,
  parameter [15:0] NO_RETAIN_MASK = 16'h0030,
  parameter NUM_PIRQ = 8,
  parameter SETTLE_BASE_CYC = `LPMC_SETTLE_BASE_CYC
) (
  input wire clk_sys_i,
  input wire srst_i,
  input wire [3:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire sleep_exec_i,
  input wire bus_cycle_end_i,
  input wire cpu_mask_i,
  input wire [NUM_PIRQ-1:0] periph_irq_i,
  input wire nmi_pin_i,
  input wire [7:0] irq_pin_i,
  input wire ext_reset_n_i,
  input wire hw_standby_n_i,
  output reg [3:0] mode_o,
  output reg cpu_halt_o,
  output reg cpu_subclk_o,
  output reg osc_run_o,
  output reg sys_clk_en_o,
  output reg chip_reset_o,
  output reg io_hold_o,
  output reg io_hiz_o,
  output reg [2:0] sys_clk_div_o,
  output reg [NUM_MOD-1:0] periph_clk_en_o,
  output reg [NUM_MOD-1:0] periph_access_en_o,
  output reg [NUM_MOD-1:0] periph_retain_o,
  output reg irq_exc_start_o,
  output reg direct_exc_start_o,
  output reg reset_exc_start_o
);

  // Mode codes, also shown in the status register
  localparam [3:0] MD_HIGH = 4'h0;
  localparam [3:0] MD_SUBACT = 4'h1;
  localparam [3:0] MD_SUBSLP = 4'h2;
  localparam [3:0] MD_WATCH = 4'h3;
  localparam [3:0] MD_SWSTBY = 4'h4;
  localparam [3:0] MD_SETTLE = 4'h5;
  localparam [3:0] MD_RSTHOLD = 4'h6;
  localparam [3:0] MD_HWSTBY = 4'h7;

  localparam CNT_W = 24;

  // Settling count for a given select code; the base is a parameter so
  // simulation can shorten it
  function [CNT_W-1:0] settle_cycles;
    input [2:0] sel;
    reg [CNT_W-1:0] base;
    begin
      base = SETTLE_BASE_CYC[CNT_W-1:0];
      settle_cycles = base << sel;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when 2 and 3 agree

  localparam PIN_W = 11;
  wire [PIN_W-1:0] pin_raw;
  reg [PIN_W-1:0] pin_s1_r;
  reg [PIN_W-1:0] pin_s2_r;
  reg [PIN_W-1:0] pin_s3_r;
  reg [PIN_W-1:0] pin_filt_r;

  assign pin_raw = {hw_standby_n_i, ext_reset_n_i, nmi_pin_i, irq_pin_i};

  // Pins idle high for the active-low ones, low for the interrupts
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_s1_r <= 11'h600;
      pin_s2_r <= 11'h600;
      pin_s3_r <= 11'h600;
      pin_filt_r <= 11'h600;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_filt_r <= pin_s3_r;
      end
    end
  end

  wire [7:0] irq_lvl = pin_filt_r[7:0];
  wire nmi_lvl = pin_filt_r[8];
  wire reset_low = ~pin_filt_r[9];
  wire hw_standby_pin_low = ~pin_filt_r[10];

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  reg [6:0] hw_standby_pin_ctrl_r;
  reg [1:0] lp_ctrl_r;
  reg wdt_ctrl_r;
  reg [15:0] mstop_r;
  reg [7:0] irq_en_r;
  reg [NUM_MOD-1:0] stop_act_r;
  reg [3:0] mode_r;
  reg [3:0] mode_nxt;

  wire standby_select = hw_standby_pin_ctrl_r[`LPMC_SSEL_BIT];
  wire [2:0] settling_time_select = hw_standby_pin_ctrl_r[`LPMC_STS_MSB:`LPMC_STS_LSB];
  wire [2:0] system_clock_divider = hw_standby_pin_ctrl_r[`LPMC_SCKD_MSB:`LPMC_SCKD_LSB];
  wire low_speed_on = lp_ctrl_r[`LPMC_LOW_SPEED_ON_BIT];
  wire direct_transfer_on = lp_ctrl_r[`LPMC_DIRECT_TRANSFER_ON_BIT];
  wire prescaler_select_wdt = wdt_ctrl_r;

  // Software writes; module stop bits default to all stopped
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      hw_standby_pin_ctrl_r <= `LPMC_HW_STANDBY_PIN_CTRL_RST;
      lp_ctrl_r <= `LPMC_LP_CTRL_RST;
      wdt_ctrl_r <= `LPMC_WDT_CTRL_RST;
      mstop_r <= `LPMC_MSTOP_RST;
      irq_en_r <= `LPMC_IRQ_EN_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `LPMC_HW_STANDBY_PIN_CTRL_OFS: hw_standby_pin_ctrl_r <= reg_wdata_i[6:0];
        `LPMC_LP_CTRL_OFS: lp_ctrl_r <= reg_wdata_i[1:0];
        `LPMC_WDT_CTRL_OFS: wdt_ctrl_r <= reg_wdata_i[0];
        `LPMC_MSTOP_OFS: mstop_r <= reg_wdata_i;
        `LPMC_IRQ_EN_OFS: irq_en_r <= reg_wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Flags a divider left nonzero while the CPU runs on the subclock
  wire sckd_err = (mode_r == MD_SUBACT) && (system_clock_divider != 3'h0);

  // Read data in the cycle after the strobe; unmapped reads give zero
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `LPMC_HW_STANDBY_PIN_CTRL_OFS: reg_rdata_o <= {9'h000, hw_standby_pin_ctrl_r};
        `LPMC_LP_CTRL_OFS: reg_rdata_o <= {14'h0000, lp_ctrl_r};
        `LPMC_WDT_CTRL_OFS: reg_rdata_o <= {15'h0000, wdt_ctrl_r};
        `LPMC_MSTOP_OFS: reg_rdata_o <= mstop_r;
        `LPMC_IRQ_EN_OFS: reg_rdata_o <= {8'h00, irq_en_r};
        `LPMC_STATUS_OFS: reg_rdata_o <= {11'h000, sckd_err, mode_r};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Module stop: requests only land at a bus cycle boundary so a module
  // never halts in the middle of an access

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      stop_act_r <= {NUM_MOD{1'b1}};
    end else if (bus_cycle_end_i) begin
      stop_act_r <= mstop_r[NUM_MOD-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake sources

  // Disabled IRQs and CPU-masked peripheral interrupts are ignored
  wire ext_wake = nmi_lvl | (|(irq_lvl & irq_en_r));
  wire periph_wake = (|periph_irq_i) & ~cpu_mask_i;
  wire any_wake = ext_wake | periph_wake;

  // Mode bits are taken as they stand in the sleep cycle
  wire sleep_s0_l1_p1 = ~standby_select & low_speed_on & prescaler_select_wdt;
  wire sleep_s1_d0_p1 = standby_select & ~direct_transfer_on & prescaler_select_wdt;
  wire sleep_s1_all = standby_select & direct_transfer_on & low_speed_on &
                      prescaler_select_wdt;
  wire sleep_s1_d1_l0 = standby_select & direct_transfer_on & ~low_speed_on &
                        prescaler_select_wdt;
  wire sleep_s1_l0_p0 = standby_select & ~low_speed_on & ~prescaler_select_wdt;

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  reg [CNT_W-1:0] settle_cnt_r;
  reg [CNT_W-1:0] settle_cnt_nxt;
  reg settle_direct_r;
  reg settle_direct_nxt;
  reg irq_exc_nxt;
  reg direct_exc_nxt;
  reg reset_exc_nxt;

  // Standby pin beats reset pin, which beats everything else
  always @* begin
    mode_nxt = mode_r;
    settle_cnt_nxt = settle_cnt_r;
    settle_direct_nxt = settle_direct_r;
    irq_exc_nxt = 1'b0;
    direct_exc_nxt = 1'b0;
    reset_exc_nxt = 1'b0;
    if (hw_standby_pin_low && mode_r != MD_HWSTBY) begin
      mode_nxt = MD_HWSTBY;
    end else if (reset_low && mode_r != MD_HWSTBY && mode_r != MD_RSTHOLD) begin
      mode_nxt = MD_RSTHOLD;
    end else begin
      case (mode_r)
        MD_HIGH: begin
          if (sleep_exec_i) begin
            if (sleep_s1_all) begin
              mode_nxt = MD_SUBACT;
              direct_exc_nxt = 1'b1;
            end else if (sleep_s1_d0_p1) begin
              mode_nxt = MD_WATCH;
            end else if (sleep_s1_l0_p0) begin
              mode_nxt = MD_SWSTBY;
            end
          end
        end
        MD_SUBACT: begin
          // Only a sleep leaves here unless a pin acts
          if (sleep_exec_i) begin
            if (sleep_s0_l1_p1) begin
              mode_nxt = MD_SUBSLP;
            end else if (sleep_s1_d0_p1) begin
              mode_nxt = MD_WATCH;
            end else if (sleep_s1_d1_l0) begin
              mode_nxt = MD_SETTLE;
              settle_cnt_nxt = settle_cycles(settling_time_select);
              settle_direct_nxt = 1'b1;
            end
          end
        end
        MD_SUBSLP: begin
          if (any_wake) begin
            mode_nxt = MD_SUBACT;
            irq_exc_nxt = 1'b1;
          end
        end
        MD_WATCH: begin
          if (any_wake) begin
            if (low_speed_on) begin
              mode_nxt = MD_SUBACT;
              irq_exc_nxt = 1'b1;
            end else begin
              mode_nxt = MD_SETTLE;
              settle_cnt_nxt = settle_cycles(settling_time_select);
              settle_direct_nxt = 1'b0;
            end
          end
        end
        MD_SWSTBY: begin
          if (ext_wake) begin
            mode_nxt = MD_SETTLE;
            settle_cnt_nxt = settle_cycles(settling_time_select);
            settle_direct_nxt = 1'b0;
          end
        end
        MD_SETTLE: begin
          if (settle_cnt_r <= 24'h000001) begin
            mode_nxt = MD_HIGH;
            settle_cnt_nxt = 24'h000000;
            direct_exc_nxt = settle_direct_r;
            irq_exc_nxt = ~settle_direct_r;
          end else begin
            settle_cnt_nxt = settle_cnt_r - 24'h000001;
          end
        end
        MD_RSTHOLD: begin
          // Oscillator stability is the pin driver's job before release
          if (!reset_low) begin
            mode_nxt = MD_HIGH;
            reset_exc_nxt = 1'b1;
          end
        end
        MD_HWSTBY: begin
          if (!hw_standby_pin_low) begin
            mode_nxt = MD_RSTHOLD;
          end
        end
        default: begin
          mode_nxt = MD_HIGH;
        end
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      mode_r <= MD_HIGH;
      settle_cnt_r <= 24'h000000;
      settle_direct_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      settle_direct_r <= settle_direct_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output decode, from the next mode so outputs flop with the state

  reg [NUM_MOD-1:0] run_mask;

  // Which modules the mode allows to run at all
  always @* begin
    case (mode_nxt)
      MD_HIGH, MD_SETTLE: run_mask = {NUM_MOD{1'b1}};
      MD_SUBACT: run_mask = LOWPWR_KEEP_MASK[NUM_MOD-1:0];
      MD_SUBSLP: run_mask = LOWPWR_KEEP_MASK[NUM_MOD-1:0];
      MD_WATCH: run_mask = WATCH_KEEP_MASK[NUM_MOD-1:0];
      default: run_mask = {NUM_MOD{1'b0}};
    endcase
  end

  wire halt_nxt = (mode_nxt == MD_SUBSLP) || (mode_nxt == MD_WATCH) ||
                  (mode_nxt == MD_SWSTBY) || (mode_nxt == MD_RSTHOLD) ||
                  (mode_nxt == MD_HWSTBY) || (mode_nxt == MD_SETTLE);
  // Halted CPU keeps its registers since no reset reaches it here
  wire hold_nxt = (mode_nxt == MD_SUBSLP) || (mode_nxt == MD_WATCH) ||
                  (mode_nxt == MD_SWSTBY) || (mode_nxt == MD_SETTLE);
  wire osc_nxt = (mode_nxt == MD_HIGH) || (mode_nxt == MD_SETTLE) ||
                 (mode_nxt == MD_RSTHOLD);

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      mode_o <= MD_HIGH;
      cpu_halt_o <= 1'b0;
      cpu_subclk_o <= 1'b0;
      osc_run_o <= 1'b1;
      sys_clk_en_o <= 1'b1;
      chip_reset_o <= 1'b0;
      io_hold_o <= 1'b0;
      io_hiz_o <= 1'b0;
      sys_clk_div_o <= 3'h0;
      periph_clk_en_o <= {NUM_MOD{1'b0}};
      periph_access_en_o <= {NUM_MOD{1'b0}};
      periph_retain_o <= {NUM_MOD{1'b1}};
      irq_exc_start_o <= 1'b0;
      direct_exc_start_o <= 1'b0;
      reset_exc_start_o <= 1'b0;
    end else begin
      mode_o <= mode_nxt;
      cpu_halt_o <= halt_nxt;
      cpu_subclk_o <= (mode_nxt == MD_SUBACT);
      osc_run_o <= osc_nxt;
      // System clock, not the peripheral clocks, runs once the synchronised reset pin puts the mode in reset hold
      sys_clk_en_o <= osc_nxt;
      chip_reset_o <= (mode_nxt == MD_RSTHOLD) || (mode_nxt == MD_HWSTBY);
      // Port outputs keep driving, high levels too, so no current saving
      io_hold_o <= hold_nxt;
      io_hiz_o <= (mode_nxt == MD_HWSTBY);
      sys_clk_div_o <= system_clock_divider;
      periph_clk_en_o <= run_mask & ~stop_act_r;
      // Stopped modules refuse register reads and writes
      periph_access_en_o <= ~stop_act_r;
      // Serial and PWM units may lose state while stopped
      periph_retain_o <= ~(stop_act_r & NO_RETAIN_MASK[NUM_MOD-1:0]);
      irq_exc_start_o <= irq_exc_nxt;
      direct_exc_start_o <= direct_exc_nxt;
      reset_exc_start_o <= reset_exc_nxt;
    end
  end

endmodule // lpmc_top

// >>> common/lpmc_regs.vh
`ifndef LPMC_REGS_VH
`define LPMC_REGS_VH

// Register indices on the plain register port
`define LPMC_HW_STANDBY_PIN_CTRL_OFS 4'h0
`define LPMC_LP_CTRL_OFS 4'h1
`define LPMC_WDT_CTRL_OFS 4'h2
`define LPMC_MSTOP_OFS 4'h3
`define LPMC_IRQ_EN_OFS 4'h4
`define LPMC_STATUS_OFS 4'h5

// Field positions in standby_control_reg
`define LPMC_SSEL_BIT 0
`define LPMC_STS_LSB 1
`define LPMC_STS_MSB 3
`define LPMC_SCKD_LSB 4
`define LPMC_SCKD_MSB 6

// Field positions in low_power_control_reg
`define LPMC_LOW_SPEED_ON_BIT 0
`define LPMC_DIRECT_TRANSFER_ON_BIT 1

// Field position in watchdog_ctrl_status_reg
`define LPMC_PSS_BIT 0

// Field positions in the status register
`define LPMC_MODE_LSB 0
`define LPMC_MODE_MSB 3
`define LPMC_SCKD_ERR_BIT 4

// Reset values
`define LPMC_HW_STANDBY_PIN_CTRL_RST 7'h00
`define LPMC_LP_CTRL_RST 2'h0
`define LPMC_WDT_CTRL_RST 1'h0
`define LPMC_MSTOP_RST 16'hffff
`define LPMC_IRQ_EN_RST 8'h00

// Oscillator settling base count, doubled per settling_time_select step
`define LPMC_SETTLE_BASE_CYC 8192

`endif

// >>> verification/lpmc_top_chk_sva.sv
`timescale 1ns/1ps
module lpmc_top_chk #(
  parameter NUM_MOD = 16,
  parameter [15:0] LOWPWR_KEEP_MASK = 16'h000f
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic sleep_exec_i,
  input wire logic [3:0] mode_o,
  input wire logic cpu_halt_o,
  input wire logic cpu_subclk_o,
  input wire logic osc_run_o,
  input wire logic sys_clk_en_o,
  input wire logic io_hold_o,
  input wire logic io_hiz_o,
  input wire logic [NUM_MOD-1:0] periph_clk_en_o,
  input wire logic irq_exc_start_o,
  input wire logic direct_exc_start_o,
  input wire logic reset_exc_start_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Subactive and subsleep gate everything but the timers and watchdogs
  a_sub_gates: assert property (mode_o == 4'h1 |-> (periph_clk_en_o & ~LOWPWR_KEEP_MASK) == 0)
    else $error("peripheral clocked in subactive");
  a_subsleep_gates: assert property (mode_o == 4'h2 |-> (periph_clk_en_o & ~LOWPWR_KEEP_MASK) == 0)
    else $error("peripheral clocked in subsleep");
  a_subclk_mode: assert property (cpu_subclk_o == (mode_o == 4'h1))
    else $error("subclock flag disagrees with mode");
  a_halt_subsleep: assert property (mode_o == 4'h2 |-> cpu_halt_o && io_hold_o)
    else $error("cpu running or ports free in subsleep");
  // Wake from subsleep must land in subactive with the exception pulse
  a_wake_subact: assert property (($past(mode_o) == 4'h2 && !(mode_o inside {4'h2, 4'h6, 4'h7}))
    |-> mode_o == 4'h1 && irq_exc_start_o)
    else $error("subsleep wake went astray");
  a_direct_exc: assert property (($past(mode_o) == 4'h0 && mode_o == 4'h1) |-> direct_exc_start_o)
    else $error("direct transition without exception pulse");
  // Only a sleep or a pin may leave subactive
  a_sub_exit: assert property (($past(mode_o) == 4'h1 && mode_o != 4'h1)
    |-> $past(sleep_exec_i) || mode_o inside {4'h6, 4'h7})
    else $error("subactive left without cause");
  a_rst_clock: assert property (mode_o == 4'h6 |-> osc_run_o && sys_clk_en_o)
    else $error("reset hold without system clock");
  a_rst_exc: assert property (($past(mode_o) == 4'h6 && mode_o == 4'h0) |-> reset_exc_start_o)
    else $error("reset release without exception pulse");
  a_hw_hiz: assert property (io_hiz_o == (mode_o == 4'h7))
    else $error("port float disagrees with standby");
  c_wake: cover property (mode_o == 4'h2 ##[1:60] mode_o == 4'h1);
  c_rst: cover property (reset_exc_start_o);
  c_hw_standby_pin: cover property (mode_o == 4'h7);
endmodule // lpmc_top_chk

bind lpmc_top lpmc_top_chk #(.NUM_MOD(NUM_MOD), .LOWPWR_KEEP_MASK(LOWPWR_KEEP_MASK)) u_chk (
  .clk_sys_i, .srst_i, .sleep_exec_i, .mode_o, .cpu_halt_o, .cpu_subclk_o, .osc_run_o,
  .sys_clk_en_o, .io_hold_o, .io_hiz_o, .periph_clk_en_o, .irq_exc_start_o,
  .direct_exc_start_o, .reset_exc_start_o);

// >>> verification/lpmc_pin_model.sv
`timescale 1ns/1ps
module lpmc_pin_model #(
  parameter HOLD_CYC = 16
) (
  input wire logic clk_i,
  input wire logic osc_run_i,
  input wire logic rst_req_i,
  input wire logic hw_standby_pin_req_i,
  output logic ext_reset_n_o = 1'b1,
  output logic hw_standby_n_o
);
  logic [7:0] stab_r = 8'h00;
  assign hw_standby_n_o = !hw_standby_pin_req_i;
  // Reset stays low until the oscillator has run long enough, even if released early
  always @(posedge clk_i) begin
    if (ext_reset_n_o || !osc_run_i)
      stab_r <= 8'h00;
    else if (stab_r < HOLD_CYC)
      stab_r <= stab_r + 8'h01;
    ext_reset_n_o <= !(rst_req_i || (!ext_reset_n_o && stab_r < HOLD_CYC));
  end
endmodule // lpmc_pin_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
`include "lpmc_regs.vh"
module testbench;
  logic clk_sys_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, sleep_exec_i = 0;
  logic bus_cycle_end_i = 0, cpu_mask_i = 0, rst_req = 0, hw_standby_pin_req = 0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000, rd_v, reg_rdata_o, periph_clk_en_o;
  logic [15:0] periph_access_en_o, periph_retain_o;
  logic [7:0] periph_irq_i = 8'h00, irq_pin_i = 8'h00;
  logic ext_reset_n_i, hw_standby_n_i, cpu_halt_o, cpu_subclk_o, osc_run_o, sys_clk_en_o;
  logic chip_reset_o, io_hold_o, io_hiz_o, irq_exc_start_o, direct_exc_start_o;
  logic reset_exc_start_o;
  logic [3:0] mode_o;
  logic [2:0] sys_clk_div_o, exc_r;
  int fail_count = 0, num_checks = 0, cyc = 0, k, exp_mode, wait_n, sts_sel = 0;
  logic nmi_pin_i = 1'b0;
  localparam int SETTLE_BASE = 4;

  always #20 clk_sys_i = ~clk_sys_i;
  lpmc_top #(.SETTLE_BASE_CYC(SETTLE_BASE)) DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sleep_exec_i(sleep_exec_i),
    .bus_cycle_end_i(bus_cycle_end_i), .cpu_mask_i(cpu_mask_i), .periph_irq_i(periph_irq_i),
    .nmi_pin_i(nmi_pin_i), .irq_pin_i(irq_pin_i), .ext_reset_n_i(ext_reset_n_i),
    .hw_standby_n_i(hw_standby_n_i), .mode_o(mode_o), .cpu_halt_o(cpu_halt_o),
    .cpu_subclk_o(cpu_subclk_o), .osc_run_o(osc_run_o), .sys_clk_en_o(sys_clk_en_o),
    .chip_reset_o(chip_reset_o), .io_hold_o(io_hold_o), .io_hiz_o(io_hiz_o),
    .sys_clk_div_o(sys_clk_div_o), .periph_clk_en_o(periph_clk_en_o),
    .periph_access_en_o(periph_access_en_o), .periph_retain_o(periph_retain_o),
    .irq_exc_start_o(irq_exc_start_o), .direct_exc_start_o(direct_exc_start_o),
    .reset_exc_start_o(reset_exc_start_o));
  lpmc_pin_model u_pins (.clk_i(clk_sys_i), .osc_run_i(osc_run_o), .rst_req_i(rst_req),
    .hw_standby_pin_req_i(hw_standby_pin_req), .ext_reset_n_o(ext_reset_n_i), .hw_standby_n_o(hw_standby_n_i));

  //////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // A hang costs a mismatch rather than a silent stall
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // Bus master: strobes last one cycle and are launched just after an edge
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    rd_v = reg_rdata_o;
  endtask
  // Reference model: target mode of a sleep from the control bits
  function int sleep_target(int m, int s, int d, int l, int p);
    if (m == 0 && s && d && l && p) return 1;
    if (m == 1 && !s && l && p) return 2;
    if (m == 1 && s && !d && p) return 3;
    if (m == 1 && s && d && !l && p) return 0;
    if (m == 0 && s && !l && !p) return 4;
    return m;
  endfunction
  // Bounded wait; the exception pulses are captured as the mode arrives
  task wait_mode(input int m);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while (mode_o !== 4'(m) && n < 60) begin
      @(negedge clk_sys_i);
      n++;
    end
    exc_r = {irq_exc_start_o, direct_exc_start_o, reset_exc_start_o};
    wait_n = n;
  endtask
  task sleep(input int s, input int d, input int l, input int p);
    wr(`LPMC_WDT_CTRL_OFS, 16'(p));
    wr(`LPMC_LP_CTRL_OFS, 16'(d * 2 + l));
    // Divider field stays zero, as the subclock CPU needs
    wr(`LPMC_HW_STANDBY_PIN_CTRL_OFS, 16'(s + sts_sel * 2));
    exp_mode = sleep_target(exp_mode, s, d, l, p);
    @(posedge clk_sys_i);
    sleep_exec_i <= 1'b1;
    @(posedge clk_sys_i);
    sleep_exec_i <= 1'b0;
    wait_mode(exp_mode);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h87b5));
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    exp_mode = 0;
    rd(`LPMC_MSTOP_OFS);
    check(rd_v, 16'hffff);
    check(periph_access_en_o, 16'h0000);
    check(periph_retain_o, 16'hffcf);
    rd(4'hf);
    check(rd_v, 16'h0000);
    wr(`LPMC_WDT_CTRL_OFS, 16'h0001);
    sleep(1, 1, 1, 1);
    check(16'(mode_o), 16'h0001);
    check(16'(exc_r), 16'h0002);
    // Stop bits only land at the end of a bus cycle
    wr(`LPMC_MSTOP_OFS, 16'h0000);
    repeat (3) @(negedge clk_sys_i);
    check(periph_access_en_o, 16'h0000);
    @(posedge clk_sys_i);
    bus_cycle_end_i <= 1'b1;
    @(posedge clk_sys_i);
    bus_cycle_end_i <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check(periph_clk_en_o, 16'h000f);
    check(periph_access_en_o, 16'hffff);
    check(periph_retain_o, 16'hffff);
    sleep(0, 0, 1, 1);
    check(16'(mode_o), 16'h0002);
    check(16'({cpu_halt_o, io_hold_o}), 16'h0003);
    // Disabled and masked requests must not wake
    k = $urandom % 8;
    @(posedge clk_sys_i);
    cpu_mask_i <= 1'b1;
    periph_irq_i <= 8'($urandom) | 8'h01;
    irq_pin_i <= 8'(1 << k);
    repeat (12) @(negedge clk_sys_i);
    check(16'(mode_o), 16'h0002);
    wr(`LPMC_IRQ_EN_OFS, 16'(1 << k));
    exp_mode = 1;
    wait_mode(exp_mode);
    check(16'(mode_o), 16'h0001);
    check(16'(exc_r), 16'h0004);
    @(posedge clk_sys_i);
    irq_pin_i <= 8'h00;
    cpu_mask_i <= 1'b0;
    periph_irq_i <= 8'h00;
    // Watch from subactive; an NMI with low speed on comes straight back
    sleep(1, 0, 1, 1);
    check(16'(mode_o), 16'h0003);
    @(posedge clk_sys_i);
    nmi_pin_i <= 1'b1;
    exp_mode = 1;
    wait_mode(exp_mode);
    check(16'(mode_o), 16'h0001);
    check(16'(exc_r), 16'h0004);
    @(posedge clk_sys_i);
    nmi_pin_i <= 1'b0;
    rd(`LPMC_STATUS_OFS);
    check(rd_v, 16'h0001);
    check(16'(sys_clk_div_o), 16'h0000);
    // Random settling select, so the length of the wait is checked too
    sts_sel = 1 + $urandom % 3;
    sleep(1, 1, 0, 1);
    check(16'(mode_o), 16'h0000);
    check(16'(exc_r), 16'h0002);
    check(16'(wait_n), 16'(SETTLE_BASE << sts_sel));
    @(posedge clk_sys_i);
    rst_req <= 1'b1;
    wait_mode(6);
    check(16'({mode_o, sys_clk_en_o, chip_reset_o}), 16'h001b);
    @(posedge clk_sys_i);
    rst_req <= 1'b0;
    wait_mode(0);
    check(16'(exc_r), 16'h0001);
    @(posedge clk_sys_i);
    hw_standby_pin_req <= 1'b1;
    wait_mode(7);
    check(16'({mode_o, io_hiz_o}), 16'h000f);
    @(posedge clk_sys_i);
    hw_standby_pin_req <= 1'b0;
    wait_mode(0);
    check(16'(mode_o), 16'h0000);
    // Software standby keeps the ports driven until an NMI wakes it
    sleep(1, 0, 0, 0);
    check(16'({mode_o, io_hold_o}), 16'h0009);
    @(posedge clk_sys_i);
    nmi_pin_i <= 1'b1;
    wait_mode(0);
    check(16'({mode_o, io_hold_o}), 16'h0000);
    tally_and_finish();
  end
endmodule // testbench
